/* include/blsq_pkg.sv */
// blsq_pkg: shared widths, register map, condition codes and carriers
// for the branch and loop sequencer; assumes a 24-bit program address space.
package blsq_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 32;
    localparam int PC_DEPTH = 30;
    localparam int PC_PTR_W = 5;
    localparam int LOOP_DEPTH = 6;
    localparam int LOOP_PTR_W = 3;
    localparam int COND_W = 5;
    localparam int STICKY_STATUS_W = 5;
    localparam int REG_AW = 2;

    localparam logic [PC_PTR_W-1:0] PC_ALMOST = 5'h1D;
    localparam logic [COND_W-1:0] COND_LCE = 5'h0F;
    localparam logic [COND_W-1:0] COND_ALWAYS = 5'h1F;
    localparam logic [ADDR_W-1:0] DELAYED_RET_OFS = 24'h000003;
    localparam logic [ADDR_W-1:0] LOOP_TEST_OFS = 24'h000002;
    localparam logic [1:0] DELAY_SLOTS = 2'h2;
    localparam logic [1:0] LOOP_TYPE_COND = 2'h0;

    // register indices on the plain register port
    localparam logic [REG_AW-1:0] REG_STICKY = 2'h0;
    localparam logic [REG_AW-1:0] REG_PC_SP = 2'h1;
    localparam logic [REG_AW-1:0] REG_PC_TOP = 2'h2;
    localparam logic [REG_AW-1:0] REG_LOOP_TOP = 2'h3;

    // sticky_status bit positions; full and empty are live, overflows sticky
    localparam int STK_PC_FULL = 0;
    localparam int STK_PC_EMPTY = 1;
    localparam int STK_PC_OVF = 2;
    localparam int STK_LOOP_OVF = 3;
    localparam int STK_LOOP_EMPTY = 4;
    localparam logic [STICKY_STATUS_W-1:0] STICKY_STATUS_RESET = 5'h00;

    // overflow_irq bit positions
    localparam int OVI_LOOP = 0;
    localparam int OVI_COUNT = 1;
    localparam int OVI_STATUS = 2;

    typedef enum logic [5:0] {
        BK_NONE = 6'h01,
        BK_JUMP = 6'h02,
        BK_CALL = 6'h04,
        BK_RTS = 6'h08,
        BK_RTI = 6'h10,
        BK_LOOP = 6'h20
    } blsq_kind_e;

    typedef enum logic [2:0] {
        TM_INDIRECT = 3'h1,
        TM_DIRECT = 3'h2,
        TM_RELATIVE = 3'h4
    } blsq_tmode_e;

    typedef struct packed {
        logic valid;
        blsq_kind_e kind;
        logic has_cond;
        logic [COND_W-1:0] cond;
        blsq_tmode_e tmode;
        logic delayed;
        logic loop_abort;
        logic status_pushed;
        logic [4:0] irq_idx;
        logic [ADDR_W-1:0] imm;
        logic [1:0] loop_type;
    } blsq_instr_s;

    typedef struct packed {
        logic az, an, av, ac, mv, mn, sv, sz, af, alusat;
        logic [3:0] fi;
        logic bit_test_flag;
        logic bus_master;
        logic bm_disable;
        logic loop_count_expired;
    } blsq_flags_s;

    typedef struct packed {
        logic [1:0] loop_type;
        logic rsvd;
        logic [COND_W-1:0] cond;
        logic [ADDR_W-1:0] end_addr;
    } blsq_loop_s;

    typedef struct packed {
        logic valid;
        logic squash;
        logic [ADDR_W-1:0] addr;
    } blsq_redirect_s;
endpackage

/* hdl/blsq_cond.sv */
// blsq_cond: evaluates one 5-bit condition or termination code.
// assumes flags are settled in the cycle the code is evaluated.
`timescale 1ns/1ps
module blsq_cond (
    input wire blsq_pkg::blsq_flags_s flags_in,
    input wire logic [blsq_pkg::COND_W-1:0] code_in,
    input wire logic loop_ctx_in,
    output logic result_out
);
    logic [14:0] base;
    logic lt_core;
    logic le_core;
    logic bm_eff;

    assign lt_core = ~flags_in.af & (flags_in.an ^ (flags_in.av & ~flags_in.alusat));
    assign le_core = lt_core | (flags_in.af & flags_in.an) | flags_in.az;
    // bus master condition is forced false unless enabled
    assign bm_eff = flags_in.bus_master & ~flags_in.bm_disable;
    assign base = {bm_eff, flags_in.bit_test_flag, flags_in.fi, flags_in.sz, flags_in.sv,
                   flags_in.mn, flags_in.mv, flags_in.av, flags_in.ac, le_core,
                   lt_core | (flags_in.af & flags_in.an & ~flags_in.az), flags_in.az};

    // codes 16..30 mirror 0..14 inverted; 15 and 31 depend on context
    assign result_out = (code_in == blsq_pkg::COND_ALWAYS) ? ~loop_ctx_in :
                        (code_in == blsq_pkg::COND_LCE) ? ~(flags_in.loop_count_expired ^ loop_ctx_in) :
                        code_in[4] ? ~base[code_in[3:0]] : base[code_in[3:0]];
endmodule

/* hdl/blsq_stack.sv */
// blsq_stack: lifo with pointer, full and overflow state, registered top.
// assumes push and pop are never requested together by the caller.
`timescale 1ns/1ps
module blsq_stack #(
    parameter int DEPTH = 30,
    parameter int WIDTH = 24,
    parameter int PW = 5
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic [WIDTH-1:0] data_in,
    input wire logic load_in,
    input wire logic [PW-1:0] load_val_in,
    output logic [WIDTH-1:0] top_out,
    output logic [PW-1:0] ptr_out,
    output logic full_out,
    output logic ovf_out
);
    localparam logic [PW-1:0] FULL_V = PW'(DEPTH);
    localparam logic [PW-1:0] OVF_V = PW'(DEPTH + 1);
    localparam logic [PW-1:0] ONE = PW'(1);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] next_ptr;
    logic in_range;

    assign full_out = (ptr_out == FULL_V);
    assign ovf_out = (ptr_out == OVF_V);
    assign next_ptr = push_in ? (ptr_out >= FULL_V ? OVF_V : ptr_out + ONE) :
                      pop_in ? (ptr_out == '0 ? ptr_out : ovf_out ? FULL_V : ptr_out - ONE) :
                      (load_in && !ovf_out) ? load_val_in : ptr_out;
    assign in_range = (next_ptr != '0) && (next_ptr <= FULL_V);

    always_ff @(posedge clk_in) begin
        if (push_in && ptr_out < FULL_V) begin
            mem[ptr_out] <= data_in;
        end
    end

    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ptr_out <= '0;
            top_out <= '0;
        end else begin
            ptr_out <= next_ptr;
            top_out <= push_in ? data_in : in_range ? mem[next_ptr - ONE] : '0;
        end
    end

    ovf_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        ovf_out && !pop_in |=> ovf_out) else $error("overflow state left without pop");
endmodule

/* hdl/blsq_sequencer.sv */
// blsq_sequencer: branch, return and loop control at the execute stage.
// assumes one execute-stage instruction per cycle and a fetch unit that
// obeys redirect one cycle after the branch executes.
`timescale 1ns/1ps
module blsq_sequencer (
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    input wire blsq_pkg::blsq_instr_s instr_in,
    input wire blsq_pkg::blsq_flags_s flags_in,
    input wire logic [blsq_pkg::ADDR_W-1:0] exec_pc_in,
    input wire logic [blsq_pkg::ADDR_W-1:0] decode_pc_in,
    input wire logic [blsq_pkg::ADDR_W-1:0] second_address_generator_addr_in,
    input wire logic count_push_full_in,
    input wire logic status_push_full_in,
    input wire logic [blsq_pkg::REG_AW-1:0] reg_addr_in,
    input wire logic [blsq_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [blsq_pkg::DATA_W-1:0] reg_rdata_out,
    output blsq_pkg::blsq_redirect_s redirect_out,
    output logic status_pop_out,
    output logic irq_clear_out,
    output logic [4:0] irq_clear_idx_out,
    output logic loop_count_dec_out,
    output logic irq_hold_out,
    output logic pc_stack_irq_out,
    output logic [2:0] overflow_irq_out
);
    localparam int AW = blsq_pkg::ADDR_W;

    // instruction class decode
    logic k_jump;
    logic k_call;
    logic k_rts;
    logic k_rti;
    logic k_loop;

    always_comb begin
        k_jump = 1'b0;
        k_call = 1'b0;
        k_rts = 1'b0;
        k_rti = 1'b0;
        k_loop = 1'b0;
        unique case (instr_in.kind)
            blsq_pkg::BK_NONE: k_jump = 1'b0;
            blsq_pkg::BK_JUMP: k_jump = instr_in.valid;
            blsq_pkg::BK_CALL: k_call = instr_in.valid;
            blsq_pkg::BK_RTS: k_rts = instr_in.valid;
            blsq_pkg::BK_RTI: k_rti = instr_in.valid;
            blsq_pkg::BK_LOOP: k_loop = instr_in.valid;
            default: k_jump = 1'b0;
        endcase
    end

    // condition evaluation: one for instructions, one for loop termination
    logic cond_res;
    logic term_cond_res;
    blsq_pkg::blsq_loop_s loop_top;

    blsq_cond u_instr_cond (
        .flags_in(flags_in),
        .code_in(instr_in.cond),
        .loop_ctx_in(1'b0),
        .result_out(cond_res)
    );

    blsq_cond u_term_cond (
        .flags_in(flags_in),
        .code_in(loop_top.cond),
        .loop_ctx_in(1'b1),
        .result_out(term_cond_res)
    );

    // stacks
    logic [AW-1:0] pc_top;
    logic [blsq_pkg::PC_PTR_W-1:0] pc_ptr;
    logic [blsq_pkg::LOOP_PTR_W-1:0] loop_ptr;
    logic pc_full;
    logic pc_ovf;
    logic loop_full;
    logic loop_ovf;
    logic pc_push;
    logic pc_pop;
    logic loop_push;
    logic loop_pop;
    logic [AW-1:0] pc_push_data;
    blsq_pkg::blsq_loop_s loop_push_data;
    logic sp_pend;
    logic [blsq_pkg::PC_PTR_W-1:0] sp_pend_val;
    logic [blsq_pkg::DATA_W-1:0] loop_top_raw;

    // updated at the end of the execute cycle, so a read in the next
    // cycle already sees a delayed call or return's effect
    blsq_stack #(
        .DEPTH(blsq_pkg::PC_DEPTH),
        .WIDTH(AW),
        .PW(blsq_pkg::PC_PTR_W)
    ) u_pc_stack (
        .clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .push_in(pc_push),
        .pop_in(pc_pop),
        .data_in(pc_push_data),
        .load_in(sp_pend),
        .load_val_in(sp_pend_val),
        .top_out(pc_top),
        .ptr_out(pc_ptr),
        .full_out(pc_full),
        .ovf_out(pc_ovf)
    );

    blsq_stack #(
        .DEPTH(blsq_pkg::LOOP_DEPTH),
        .WIDTH(blsq_pkg::DATA_W),
        .PW(blsq_pkg::LOOP_PTR_W)
    ) u_loop_stack (
        .clk_in(core_clk_in),
        .reset_n_in(reset_n_in),
        .push_in(loop_push),
        .pop_in(loop_pop),
        .data_in(loop_push_data),
        .load_in(1'b0),
        .load_val_in('0),
        .top_out(loop_top_raw),
        .ptr_out(loop_ptr),
        .full_out(loop_full),
        .ovf_out(loop_ovf)
    );

    assign loop_top = loop_top_raw;

    // branch decision and target
    logic is_branch;
    logic cond_ok;
    logic taken;
    logic is_ret;
    logic [AW-1:0] branch_tgt;
    logic [AW-1:0] jump_tgt;
    logic la_pop;

    assign is_branch = k_jump | k_call | k_rts | k_rti;
    assign cond_ok = ~instr_in.has_cond | cond_res;
    assign taken = is_branch & cond_ok;
    assign is_ret = k_rts | k_rti;
    assign jump_tgt = (instr_in.tmode == blsq_pkg::TM_INDIRECT) ? second_address_generator_addr_in :
                      (instr_in.tmode == blsq_pkg::TM_DIRECT) ? instr_in.imm :
                      exec_pc_in + instr_in.imm;
    assign branch_tgt = is_ret ? pc_top : jump_tgt;
    // abort only pops when a loop is actually active
    assign la_pop = taken & k_jump & instr_in.loop_abort & (loop_ptr != '0);

    // loop termination test at e-2
    logic at_test;
    logic counted;
    logic term;
    logic loop_back;
    logic loop_exit;

    assign at_test = instr_in.valid && (loop_ptr != '0) && !loop_ovf &&
                     (exec_pc_in == loop_top.end_addr - blsq_pkg::LOOP_TEST_OFS);
    assign counted = (loop_top.loop_type != blsq_pkg::LOOP_TYPE_COND);
    assign term = counted ? flags_in.loop_count_expired : term_cond_res;
    assign loop_back = at_test & ~term;
    assign loop_exit = at_test & term;

    // stack operations
    assign pc_push = (taken & k_call) | k_loop;
    assign pc_push_data = k_loop ? decode_pc_in :
                          instr_in.delayed ? exec_pc_in + blsq_pkg::DELAYED_RET_OFS :
                          decode_pc_in;
    assign pc_pop = (taken & is_ret) | la_pop | loop_exit;
    assign loop_push = k_loop;
    assign loop_push_data = '{loop_type: instr_in.loop_type, rsvd: 1'b0,
                              cond: instr_in.cond, end_addr: instr_in.imm};
    assign loop_pop = la_pop | loop_exit;

    // flow redirection towards fetch
    blsq_pkg::blsq_redirect_s next_redirect;

    assign next_redirect.valid = taken | loop_back;
    assign next_redirect.squash = taken & ~instr_in.delayed;
    // address held at zero unless a branch is taken or the loop jumps back, so the pulse is clean
    assign next_redirect.addr = loop_back ? pc_top : taken ? branch_tgt : '0;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            redirect_out <= '0;
        end else begin
            redirect_out <= next_redirect;
        end
    end

    // interrupt return side effects and loop counter decrement
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            status_pop_out <= 1'b0;
            irq_clear_out <= 1'b0;
            irq_clear_idx_out <= '0;
            loop_count_dec_out <= 1'b0;
        end else begin
            status_pop_out <= taken & k_rti & instr_in.status_pushed;
            irq_clear_out <= taken & k_rti;
            irq_clear_idx_out <= instr_in.irq_idx;
            loop_count_dec_out <= at_test & counted;
        end
    end

    // interrupt deferral across the two delay slots
    logic [1:0] hold_cnt;
    logic [1:0] next_hold_cnt;

    assign next_hold_cnt = (taken & instr_in.delayed) ? blsq_pkg::DELAY_SLOTS :
                           (hold_cnt != '0) ? hold_cnt - 2'h1 : hold_cnt;

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            hold_cnt <= '0;
            irq_hold_out <= 1'b0;
        end else begin
            hold_cnt <= next_hold_cnt;
            irq_hold_out <= (next_hold_cnt != '0);
        end
    end

    // stack status, overflow and interrupt requests
    logic [blsq_pkg::STICKY_STATUS_W-1:0] sticky_status;
    logic [blsq_pkg::STICKY_STATUS_W-1:0] sticky_status_set;
    logic [blsq_pkg::STICKY_STATUS_W-1:0] sticky_status_clr;
    logic [2:0] next_ovi;
    logic wr_sticky;
    logic wr_pc_sp;

    assign wr_sticky = reg_wr_in && (reg_addr_in == blsq_pkg::REG_STICKY);
    assign wr_pc_sp = reg_wr_in && (reg_addr_in == blsq_pkg::REG_PC_SP);
    assign next_ovi[blsq_pkg::OVI_LOOP] = loop_push & (loop_full | loop_ovf);
    assign next_ovi[blsq_pkg::OVI_COUNT] = count_push_full_in;
    assign next_ovi[blsq_pkg::OVI_STATUS] = status_push_full_in;
    assign sticky_status_set = {1'b0, next_ovi[blsq_pkg::OVI_LOOP], pc_push & pc_full, 2'b00};
    assign sticky_status_clr = wr_sticky ? reg_wdata_in[blsq_pkg::STICKY_STATUS_W-1:0] : '0;

    // write-one-to-clear; a fresh overflow in the same cycle survives
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sticky_status <= blsq_pkg::STICKY_STATUS_RESET;
            overflow_irq_out <= '0;
            pc_stack_irq_out <= 1'b0;
        end else begin
            sticky_status <= (sticky_status & ~sticky_status_clr) | sticky_status_set;
            overflow_irq_out <= next_ovi;
            pc_stack_irq_out <= (pc_ptr == blsq_pkg::PC_ALMOST);
        end
    end

    // pointer writes are staged one cycle; the stack drops them if overflowed
    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sp_pend <= 1'b0;
            sp_pend_val <= '0;
        end else begin
            sp_pend <= wr_pc_sp;
            sp_pend_val <= reg_wdata_in[blsq_pkg::PC_PTR_W-1:0];
        end
    end

    // register reads
    logic [blsq_pkg::STICKY_STATUS_W-1:0] sticky_status_view;
    logic [blsq_pkg::DATA_W-1:0] rd_mux;

    assign sticky_status_view = {loop_ptr == '0, sticky_status[blsq_pkg::STK_LOOP_OVF], sticky_status[blsq_pkg::STK_PC_OVF],
                        pc_ptr == '0, pc_full};
    assign rd_mux = (reg_addr_in == blsq_pkg::REG_STICKY) ? blsq_pkg::DATA_W'(sticky_status_view) :
                    (reg_addr_in == blsq_pkg::REG_PC_SP) ? blsq_pkg::DATA_W'(pc_ptr) :
                    (reg_addr_in == blsq_pkg::REG_PC_TOP) ? blsq_pkg::DATA_W'(pc_top) :
                    loop_top_raw & ~(blsq_pkg::DATA_W'(1) << (blsq_pkg::ADDR_W + blsq_pkg::COND_W));

    always_ff @(posedge core_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            reg_rdata_out <= '0;
        end else begin
            reg_rdata_out <= reg_rd_in ? rd_mux : '0;
        end
    end

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    sequence s_delayed_taken;
        taken && instr_in.delayed;
    endsequence

    sequence s_two_slots;
        irq_hold_out [*2];
    endsequence

    squash_nodelay_a: assert property (
        taken && !instr_in.delayed |=> redirect_out.valid && redirect_out.squash)
        else $error("non-delayed branch did not squash");
    delay_runs_a: assert property (
        s_delayed_taken |=> redirect_out.valid && !redirect_out.squash)
        else $error("delayed branch squashed its slots");
    irq_hold_a: assert property (
        s_delayed_taken |=> s_two_slots)
        else $error("interrupts not held over delay slots");
    call_push_a: assert property (
        taken && k_call && pc_ptr < blsq_pkg::PC_ALMOST && !sp_pend
        |=> pc_ptr == $past(pc_ptr) + 5'h01)
        else $error("call did not push");
    jump_nopush_a: assert property (
        taken && k_jump && !la_pop && !loop_exit && !sp_pend |=> pc_ptr == $past(pc_ptr))
        else $error("jump changed the return stack");
    ret_target_a: assert property (
        taken && is_ret |=> redirect_out.addr == $past(pc_top))
        else $error("return target is not stack top");
    rti_clear_a: assert property (
        taken && k_rti |=> irq_clear_out && irq_clear_idx_out == $past(instr_in.irq_idx))
        else $error("interrupt return did not clear latch");
    dcall_addr_a: assert property (
        taken && k_call && instr_in.delayed && !pc_full && !pc_ovf
        |=> pc_top == $past(exec_pc_in) + blsq_pkg::DELAYED_RET_OFS)
        else $error("delayed call pushed wrong address");
    loop_dec_a: assert property (
        at_test && counted |=> loop_count_dec_out ##1 !loop_count_dec_out || $past(at_test))
        else $error("counter not decremented at e-2");
    almost_irq_a: assert property (
        pc_ptr == blsq_pkg::PC_ALMOST |=> pc_stack_irq_out)
        else $error("almost-full interrupt missing");
endmodule

/* testbench/blsq_fetch_model.sv */
// blsq_fetch_model: fetch path stand-in that walks the execute address.
// assumes redirect arrives the cycle after the branch executes.
`timescale 1ns/1ps
module blsq_fetch_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire blsq_pkg::blsq_redirect_s redirect_in,
    output logic [blsq_pkg::ADDR_W-1:0] exec_pc_out,
    output logic [blsq_pkg::ADDR_W-1:0] decode_pc_out
);
    assign decode_pc_out = exec_pc_out + 24'h000001;
    // a redirect replaces the sequential address; squashed slots still advance
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            exec_pc_out <= 24'h000100;
        end else if (redirect_in.valid) begin
            exec_pc_out <= redirect_in.addr;
        end else begin
            exec_pc_out <= decode_pc_out;
        end
    end
endmodule

/* testbench/branch_loop_sequencer_test.sv */
// branch_loop_sequencer_test: register and instruction sequences against the sequencer.
// assumes the fetch model supplies execute and decode addresses.
`timescale 1ns/1ps
module branch_loop_sequencer_test;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    blsq_pkg::blsq_instr_s instr = '0;
    blsq_pkg::blsq_flags_s flags = '0;
    blsq_pkg::blsq_redirect_s redir;
    logic [23:0] epc, dpc, p, top;
    logic [1:0] raddr = 2'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic wr = 1'b0, rd = 1'b0, cnt_full = 1'b0, st_full = 1'b0;
    logic status_pop, irq_clr, dec, hold, pcirq, seen;
    logic [4:0] clr_idx;
    logic [2:0] ovf;
    int failures = 0;
    int comparisons = 0;
    always #2 core_clk = ~core_clk;
    blsq_fetch_model fetch (.clk_in(core_clk), .reset_n_in(reset_n), .redirect_in(redir),
        .exec_pc_out(epc), .decode_pc_out(dpc));
    blsq_sequencer dut (.core_clk_in(core_clk), .reset_n_in(reset_n), .instr_in(instr), .flags_in(flags),
        .exec_pc_in(epc), .decode_pc_in(dpc), .second_address_generator_addr_in(24'h00ABCD), .count_push_full_in(cnt_full),
        .status_push_full_in(st_full), .reg_addr_in(raddr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata), .redirect_out(redir), .status_pop_out(status_pop),
        .irq_clear_out(irq_clr), .irq_clear_idx_out(clr_idx), .loop_count_dec_out(dec),
        .irq_hold_out(hold), .pc_stack_irq_out(pcirq), .overflow_irq_out(ovf));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic finish_test;
        if (failures == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic rreg(input logic [1:0] a, output logic [31:0] d);
        @(posedge core_clk);
        rd <= 1'b1;
        raddr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wreg(input logic [1:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        raddr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
        #1;
    endtask
    // outputs answer one cycle after the execute edge, so sample just past it
    task automatic run(input blsq_pkg::blsq_instr_s i, output logic [23:0] pc);
        @(posedge core_clk);
        instr <= i;
        #1 pc = epc;
        @(posedge core_clk);
        instr <= '0;
        #1;
    endtask
    function automatic blsq_pkg::blsq_instr_s mk(input blsq_pkg::blsq_kind_e k,
        input blsq_pkg::blsq_tmode_e t, input logic d, input logic [23:0] a);
        mk = '0;
        mk.valid = 1'b1;
        mk.kind = k;
        mk.tmode = t;
        mk.delayed = d;
        mk.imm = a;
    endfunction
    initial begin
        blsq_pkg::blsq_instr_s i;
        repeat (20) @(posedge core_clk);
        reset_n <= 1'b1;
        rreg(2'h1, v);
        chk(v, 32'h0);
        rreg(2'h0, v);
        chk(v, 32'h12);
        run(mk(blsq_pkg::BK_CALL, blsq_pkg::TM_DIRECT, 1'b0, 24'h000400), p);
        chk(redir, {1'b1, 1'b1, 24'h000400});
        top = p + 24'h000001;
        rreg(2'h2, v);
        chk(v, {8'h0, top});
        run(mk(blsq_pkg::BK_CALL, blsq_pkg::TM_RELATIVE, 1'b1, 24'h000010), p);
        chk(redir, {1'b1, 1'b0, p + 24'h000010});
        chk(hold, 1'b1);
        rreg(2'h2, v);
        chk(v, {8'h0, p + 24'h000003});
        run(mk(blsq_pkg::BK_RTS, blsq_pkg::TM_DIRECT, 1'b0, 24'h0), p);
        chk(redir.addr, v);
        i = mk(blsq_pkg::BK_RTI, blsq_pkg::TM_DIRECT, 1'b0, 24'h0);
        i.status_pushed = 1'b1;
        i.irq_idx = 5'h07;
        run(i, p);
        chk({status_pop, irq_clr, clr_idx}, {2'b11, 5'h07});
        chk(redir.addr, top);
        rreg(2'h1, v);
        chk(v, 32'h0);
        // codes 27-30 fail with their flags set, code 31 always passes
        for (int c = 27; c < 32; c++) begin
            for (int f = 0; f < 2; f++) begin
                flags.fi <= f ? 4'hC : 4'h0;
                flags.bit_test_flag <= f[0];
                flags.bus_master <= f[0];
                i = mk(blsq_pkg::BK_JUMP, blsq_pkg::TM_INDIRECT, 1'b0, 24'h0);
                i.has_cond = 1'b1;
                i.cond = c[4:0];
                run(i, p);
                chk(redir, (f == 1 && c != 31) ? 26'h0 : {2'b11, 24'h00ABCD});
            end
        end
        rreg(2'h1, v);
        chk(v, 32'h0);
        run(mk(blsq_pkg::BK_JUMP, blsq_pkg::TM_DIRECT, 1'b0, 24'h000800), p);
        // end far enough out that e-2 is reached after the two reads below
        i = mk(blsq_pkg::BK_LOOP, blsq_pkg::TM_DIRECT, 1'b0, 24'h00080A);
        i.cond = 5'h1F;
        i.loop_type = 2'h3;
        run(i, p);
        rreg(2'h3, v);
        chk(v, 32'hDF00080A);
        rreg(2'h2, v);
        chk(v, 32'h00000801);
        seen = 1'b0;
        for (int k = 0; k < 20 && !seen; k++) begin
            @(posedge core_clk);
            instr <= mk(blsq_pkg::BK_NONE, blsq_pkg::TM_DIRECT, 1'b0, 24'h0);
            #1 seen = redir.valid;
        end
        if (!seen) begin
            failures++;
            finish_test();
        end
        chk(redir, {2'b10, 24'h000801});
        chk(dec, 1'b1);
        i = mk(blsq_pkg::BK_JUMP, blsq_pkg::TM_DIRECT, 1'b0, 24'h000900);
        i.loop_abort = 1'b1;
        run(i, p);
        rreg(2'h0, v);
        chk(v, 32'h12);
        wreg(2'h1, 32'h1D);
        rreg(2'h1, v);
        chk(v, 32'h1D);
        chk(pcirq, 1'b1);
        wreg(2'h1, 32'h1E);
        rreg(2'h0, v);
        chk(v, 32'h11);
        run(mk(blsq_pkg::BK_CALL, blsq_pkg::TM_DIRECT, 1'b0, 24'h000400), p);
        wreg(2'h1, 32'h03);
        rreg(2'h1, v);
        chk(v, 32'h1F);
        rreg(2'h0, v);
        chk(v & 32'h4, 32'h4);
        @(posedge core_clk);
        cnt_full <= 1'b1;
        @(posedge core_clk);
        cnt_full <= 1'b0;
        st_full <= 1'b1;
        #1 chk(ovf, 3'b010);
        @(posedge core_clk);
        st_full <= 1'b0;
        #1 chk(ovf, 3'b100);
        finish_test();
    end
endmodule
